// File: verif/sir_host_model.sv
// host spi controller model driving select, serial clock and serial data in
`timescale 1ns/1ns
module sir_host_model #(
  parameter int HALF_NS = 32
) (
  // spi pins driven by the host
  output logic cs_n,
  output logic sck,
  output logic si,
  // device answer
  input  wire logic so,
  input  wire logic so_oe
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  // mode 0: serial clock rests low and only runs inside a frame
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame: opcode msb first, then extra clocks capturing the output
  // ---------------------------------------------------------------
  // select falls before the opcode; also serves as dummy read
  task automatic frame(input logic [7:0] op, input int extra, output logic [71:0] rx, output logic oe);
    rx   = '0;
    oe   = 1'b0;
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < 8 + extra; i++) begin
      si = (i < 8) ? op[7-i] : ~si;
      #(HALF_NS);
      // output moves on falling edges, so it is settled here
      if (i >= 8) begin
        rx = {rx[70:0], (so_oe === 1'b1) ? so : 1'bx};
      end
      oe  = oe | (so_oe === 1'b1);
      sck = 1'b1;
      #(HALF_NS);
      sck = 1'b0;
    end
    #(HALF_NS);
    cs_n = 1'b1;
    // released data line must not look like a held value
    si = ~si;
    #200;
  endtask

  // ---------------------------------------------------------------
  // select pulse alone, clock and data left alone
  // ---------------------------------------------------------------
  // wake pulse by toggling select only
  task automatic pulse(input int width_ns);
    cs_n = 1'b0;
    #(width_ns);
    cs_n = 1'b1;
    #200;
  endtask
endmodule // sir_host_model

// File: verif/tb_serial_id_read_and_low_power_cmds.sv
// self-checking bench for the serial number read and low power command block
`timescale 1ns/1ns
module tb_serial_id_read_and_low_power_cmds;
  localparam logic [19:0] DS_ENTRY = 20'h00008;
  localparam logic [19:0] DS_EXIT  = 20'h0000A;
  localparam logic [19:0] HIB_ENTRY = 20'h00008;
  localparam logic [19:0] HIB_EXIT = 20'h00078;
  localparam logic [63:0] SN = 64'hF1E2_D3C4_B5A6_9788;

  logic                 clock;
  logic                 nrst;
  logic                 sck;
  logic                 cs_n;
  logic                 si;
  logic                 so;
  logic                 so_oe;
  logic                 acc_start;
  logic [31:0]          endurance_cnt_q;
  sir_pkg::sir_status_t status;
  sir_pkg::sir_state_t  prev_state;
  int                   run_len;
  int                   enter_len;
  int                   wake_len;
  logic                 oe_bad;
  int                   error_cnt;
  int                   samples_checked;
  logic [71:0]          rx;
  logic                 oe;

  sir_top #(.DS_ENTRY_CYC(DS_ENTRY), .WAKE_PULSE_CYC(20'h00003), .DS_EXIT_CYC(DS_EXIT),
            .HIB_ENTRY_CYC(HIB_ENTRY), .HIB_EXIT_CYC(HIB_EXIT)) dut (
    .clock(clock), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .serial_number(SN), .acc_start(acc_start), .endurance_cnt_q(endurance_cnt_q), .status(status));

  sir_host_model #(.HALF_NS(32)) host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // state length monitor
  // ---------------------------------------------------------------
  // sampled mid-cycle, once the registers launched at the rising edge have settled
  always @(negedge clock) begin
    if (status.state === prev_state) begin
      run_len++;
    end else begin
      if (prev_state === sir_pkg::SIR_ST_ENTER) enter_len = run_len;
      if (prev_state === sir_pkg::SIR_ST_WAKE) wake_len = run_len;
      run_len = 1;
    end
    prev_state = status.state;
    // output never driven outside normal operation
    if (nrst && so_oe === 1'b1 && status.state !== sir_pkg::SIR_ST_RUN) oe_bad = 1'b1;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic wait_state(input sir_pkg::sir_state_t s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clock);
      #1;
      if (status.state === s) break;
    end
    // let the length monitor record the state just left
    @(negedge clock);
    #1;
    check(72'(status.state), 72'(s), "state not reached");
  endtask

  function automatic logic [71:0] sn_stream(input logic [63:0] sn);
    logic [71:0] v;
    v = '0;
    for (int b = 0; b < 9; b++) v = {v[63:0], sn[8*(b%8)+:8]};
    return v;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_read();
    host.frame(8'hC3, 72, rx, oe);
    check(rx, sn_stream(SN), "serial stream");
    check(72'(so_oe), 72'h0, "output after select rise");
    host.frame(8'h00, 16, rx, oe);
    check(72'(oe), 72'h0, "other opcode drove output");
  endtask

  task automatic t_deep();
    host.frame(8'hBA, 0, rx, oe);
    wait_state(sir_pkg::SIR_ST_SLEEP, 100);
    check(72'(enter_len), 72'(DS_ENTRY), "deep entry length");
    check(72'(status.mode), 72'(sir_pkg::SIR_LP_DEEP), "deep mode");
    host.pulse(10);
    repeat (20) @(posedge clock);
    #1;
    check(72'(status.state), 72'(sir_pkg::SIR_ST_SLEEP), "short pulse woke");
    host.frame(8'hC3, 16, rx, oe);
    check(72'(oe), 72'h0, "driven in deep sleep");
    wait_state(sir_pkg::SIR_ST_RUN, 60);
    check(72'(wake_len), 72'(DS_EXIT), "deep exit length");
    // second wake by a long select pulse alone, clock left still
    host.frame(8'hBA, 0, rx, oe);
    wait_state(sir_pkg::SIR_ST_SLEEP, 100);
    wake_len = 0;
    host.pulse(100);
    wait_state(sir_pkg::SIR_ST_RUN, 60);
    check(72'(wake_len), 72'(DS_EXIT), "deep exit by select pulse");
    t_read();
  endtask

  task automatic t_hib();
    host.frame(8'hB9, 0, rx, oe);
    wait_state(sir_pkg::SIR_ST_SLEEP, 100);
    check(72'(enter_len), 72'(HIB_ENTRY), "hib entry length");
    check(72'(status.mode), 72'(sir_pkg::SIR_LP_HIB), "hib mode");
    host.frame(8'hC3, 8, rx, oe);
    check(72'(oe), 72'h0, "driven during hib wakeup");
    wait_state(sir_pkg::SIR_ST_RUN, 200);
    check(72'(wake_len), 72'(HIB_EXIT), "hib exit length");
    t_read();
  endtask

  task automatic t_rows();
    @(posedge clock);
    #1 acc_start = 1'b1;
    repeat (5) @(posedge clock);
    #1 acc_start = 1'b0;
    @(posedge clock);
    #1;
    check(72'(endurance_cnt_q), 72'h5, "row access count");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    acc_start = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    oe_bad = 1'b0;
    run_len = 0;
    enter_len = 0;
    wake_len = 0;
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clock);
    t_read();
    t_deep();
    t_hib();
    t_rows();
    check(72'(oe_bad), 72'h0, "output driven while asleep");
    check(72'(status.overrun), 72'h0, "unexpected overrun");
    conclude();
  end

  // whole run is some 3000 clocks; this is far beyond it
  initial begin
    #200000;
    error_cnt++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    conclude();
  end
endmodule // tb_serial_id_read_and_low_power_cmds

// File: verilog/sir_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module sir_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // head word from a register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_data <= '0;
    end else if (pop && cnt_q > (AW+1)'(1)) begin
      out_data <= mem_q[(rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1];
    end else if (push && (cnt_q == '0 || (pop && cnt_q == (AW+1)'(1)))) begin
      out_data <= in_data;
    end
  end

  chk_fifo_no_overflow : assert property (@(posedge clock) disable iff (!nrst)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count past depth");

endmodule // sir_fifo

// File: verilog/sir_pkg.sv
// types shared by the serial id and low power command block
package sir_pkg;

  typedef enum logic [1:0] {
    SIR_ST_RUN   = 2'h0,
    SIR_ST_ENTER = 2'h1,
    SIR_ST_SLEEP = 2'h3,
    SIR_ST_WAKE  = 2'h2
  } sir_state_t;

  typedef enum logic [1:0] {
    SIR_LP_NONE = 2'h0,
    SIR_LP_DEEP = 2'h1,
    SIR_LP_HIB  = 2'h2
  } sir_lp_t;

  typedef struct packed {
    sir_state_t state;
    sir_lp_t    mode;
    logic       overrun;
  } sir_status_t;

endpackage

// File: verilog/sir_regs.svh
// constants, field codes and timing counts for the serial id and low power command block
`ifndef SIR_REGS_SVH
`define SIR_REGS_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define SIR_OP_SN_READ      8'hC3
`define SIR_OP_DEEP_SLEEP   8'hBA
`define SIR_OP_HIBERNATE    8'hB9

// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define SIR_SN_BYTES        8
`define SIR_ROW_COUNT       131072
`define SIR_ROW_BITS        64
`define SIR_FIFO_DEPTH      4

// ---------------------------------------------------------------
// timing, in ns and in clock cycles
// ---------------------------------------------------------------
`define SIR_CLK_PERIOD_NS   10
`define SIR_T_DS_ENTRY_NS   3000
`define SIR_T_WAKE_PULSE_NS 100
`define SIR_T_DS_EXIT_NS    10000
`define SIR_T_HIB_ENTRY_NS  3000
`define SIR_T_HIB_EXIT_NS   450000
`define SIR_DS_ENTRY_CYC    ((`SIR_T_DS_ENTRY_NS + `SIR_CLK_PERIOD_NS - 1) / `SIR_CLK_PERIOD_NS)
`define SIR_WAKE_PULSE_CYC  ((`SIR_T_WAKE_PULSE_NS + `SIR_CLK_PERIOD_NS - 1) / `SIR_CLK_PERIOD_NS)
`define SIR_DS_EXIT_CYC     ((`SIR_T_DS_EXIT_NS + `SIR_CLK_PERIOD_NS - 1) / `SIR_CLK_PERIOD_NS)
`define SIR_HIB_ENTRY_CYC   ((`SIR_T_HIB_ENTRY_NS + `SIR_CLK_PERIOD_NS - 1) / `SIR_CLK_PERIOD_NS)
`define SIR_HIB_EXIT_CYC    (`SIR_T_HIB_EXIT_NS / `SIR_CLK_PERIOD_NS)

`endif

// File: verilog/sir_top.sv
// serial number read and low power command decoder with spi link logic
`timescale 1ns/1ns
`include "sir_regs.svh"
module sir_top #(
  parameter logic [19:0] DS_ENTRY_CYC   = 20'(`SIR_DS_ENTRY_CYC),
  parameter logic [19:0] WAKE_PULSE_CYC = 20'(`SIR_WAKE_PULSE_CYC),
  parameter logic [19:0] DS_EXIT_CYC    = 20'(`SIR_DS_EXIT_CYC),
  parameter logic [19:0] HIB_ENTRY_CYC  = 20'(`SIR_HIB_ENTRY_CYC),
  parameter logic [19:0] HIB_EXIT_CYC   = 20'(`SIR_HIB_EXIT_CYC)
) (
  // core clock and reset
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // spi pins
  input  wire logic                      sck,
  input  wire logic                      cs_n,
  input  wire logic                      si,
  output logic                           so,
  output logic                           so_oe,
  // core side
  input  wire logic [`SIR_ROW_BITS-1:0]  serial_number,
  input  wire logic                      acc_start,
  output logic [31:0]                    endurance_cnt_q,
  output sir_pkg::sir_status_t           status
);

  // ---------------------------------------------------------------
  // link domain (sck), reset by nrst or select high, the opcode word and its toggle by nrst only
  // ---------------------------------------------------------------
  logic                      link_rst_n;
  logic [2:0]                bit_cnt_q;
  logic [6:0]                shift_q;
  logic                      op_done_q;
  logic                      rd_sn_q;
  logic [7:0]                rx_byte_q;
  logic                      rx_tgl_q;
  logic [2:0]                obit_q;
  logic [2:0]                idx_q;
  logic                      so_q;
  logic                      so_oe_q;
  logic [7:0]                byte_in;
  logic                      op_end;
  logic [`SIR_ROW_BITS-1:0]  sn_q;

  assign link_rst_n = nrst && !cs_n;
  assign byte_in    = {shift_q, si};
  assign op_end     = (bit_cnt_q == 3'h7) && !op_done_q;

  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
      op_done_q <= 1'b0;
      rd_sn_q   <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= byte_in[6:0];
      if (op_end) begin
        op_done_q <= 1'b1;
        rd_sn_q   <= (byte_in == `SIR_OP_SN_READ);
      end
    end
  end

  // opcode word held stable until the next frame's opcode, handed over by toggle
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      rx_byte_q <= 8'h00;
      rx_tgl_q  <= 1'b0;
    end else if (op_end) begin
      rx_byte_q <= byte_in;
      rx_tgl_q  <= !rx_tgl_q;
    end
  end

  // output shifts on the falling edge, msb of each byte first
  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      obit_q  <= 3'h0;
      idx_q   <= 3'h0;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (rd_sn_q) begin
      so_q    <= sn_q[{idx_q, ~obit_q}];
      so_oe_q <= 1'b1;
      obit_q  <= obit_q + 3'h1;
      if (obit_q == 3'h7) begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // core domain crossings
  // ---------------------------------------------------------------
  logic       cs_m_q;
  logic       cs_s_q;
  logic       cs_d_q;
  logic       tg_m_q;
  logic       tg_s_q;
  logic       tg_d_q;
  logic       cs_rise;
  logic       cs_fall;
  logic       rx_push;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
    end else begin
      cs_m_q <= cs_n;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tg_m_q <= 1'b0;
      tg_s_q <= 1'b0;
      tg_d_q <= 1'b0;
    end else begin
      tg_m_q <= rx_tgl_q;
      tg_s_q <= tg_m_q;
      tg_d_q <= tg_s_q;
    end
  end

  assign cs_rise = cs_s_q && !cs_d_q;
  assign cs_fall = !cs_s_q && cs_d_q;
  assign rx_push = tg_s_q ^ tg_d_q;

  // copied while synced select idles; its lag ends long before the opcode is in
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sn_q <= '0;
    end else if (cs_s_q && cs_d_q) begin
      sn_q <= serial_number;
    end
  end

  // ---------------------------------------------------------------
  // opcode fifo
  // ---------------------------------------------------------------
  sir_pkg::sir_state_t state_q;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [7:0]          fifo_out_data;
  logic                overrun_q;
  logic                pop;

  // draining halts during entry only; opcodes popped in sleep or wake are dropped
  assign fifo_out_ready = (state_q != sir_pkg::SIR_ST_ENTER);
  assign pop            = fifo_out_valid && fifo_out_ready;

  sir_fifo #(
    .WIDTH (8),
    .DEPTH (`SIR_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // the link cannot be stalled, so a full fifo drops the opcode and flags it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overrun_q <= 1'b0;
    end else if (rx_push && !fifo_in_ready) begin
      overrun_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // low power decode and state machine
  // ---------------------------------------------------------------
  sir_pkg::sir_lp_t pend_q;
  sir_pkg::sir_lp_t mode_q;
  logic             fend_q;
  logic             consume;
  logic [19:0]      timer_q;
  logic [19:0]      low_cnt_q;
  logic             awake;

  assign consume = (state_q == sir_pkg::SIR_ST_RUN) && fend_q && !fifo_out_valid;

  // set wins over the clear by consume
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fend_q <= 1'b0;
    end else if (cs_rise) begin
      fend_q <= 1'b1;
    end else if (consume || state_q != sir_pkg::SIR_ST_RUN) begin
      fend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pend_q <= sir_pkg::SIR_LP_NONE;
    end else if (state_q != sir_pkg::SIR_ST_RUN || consume) begin
      pend_q <= sir_pkg::SIR_LP_NONE;
    end else if (pop) begin
      if (fifo_out_data == `SIR_OP_DEEP_SLEEP) begin
        pend_q <= sir_pkg::SIR_LP_DEEP;
      end else if (fifo_out_data == `SIR_OP_HIBERNATE) begin
        pend_q <= sir_pkg::SIR_LP_HIB;
      end else begin
        pend_q <= sir_pkg::SIR_LP_NONE;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_cnt_q <= 20'h00000;
    end else if (cs_s_q) begin
      low_cnt_q <= 20'h00000;
    end else if (low_cnt_q != 20'hFFFFF) begin
      low_cnt_q <= low_cnt_q + 20'h00001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= sir_pkg::SIR_ST_RUN;
      mode_q  <= sir_pkg::SIR_LP_NONE;
      timer_q <= 20'h00000;
    end else begin
      case (state_q)
        sir_pkg::SIR_ST_RUN: begin
          if (consume && pend_q != sir_pkg::SIR_LP_NONE) begin
            state_q <= sir_pkg::SIR_ST_ENTER;
            mode_q  <= pend_q;
            timer_q <= (pend_q == sir_pkg::SIR_LP_DEEP) ? DS_ENTRY_CYC - 20'h00001
                                                        : HIB_ENTRY_CYC - 20'h00001;
          end
        end
        sir_pkg::SIR_ST_ENTER: begin
          if (timer_q == 20'h00000) begin
            state_q <= sir_pkg::SIR_ST_SLEEP;
          end else begin
            timer_q <= timer_q - 20'h00001;
          end
        end
        sir_pkg::SIR_ST_SLEEP: begin
          if (mode_q == sir_pkg::SIR_LP_DEEP && cs_rise && low_cnt_q >= WAKE_PULSE_CYC) begin
            state_q <= sir_pkg::SIR_ST_WAKE;
            timer_q <= DS_EXIT_CYC - 20'h00001;
          end else if (mode_q == sir_pkg::SIR_LP_HIB && cs_fall) begin
            state_q <= sir_pkg::SIR_ST_WAKE;
            timer_q <= HIB_EXIT_CYC - 20'h00001;
          end
        end
        sir_pkg::SIR_ST_WAKE: begin
          if (timer_q == 20'h00000) begin
            state_q <= sir_pkg::SIR_ST_RUN;
            mode_q  <= sir_pkg::SIR_LP_NONE;
          end else begin
            timer_q <= timer_q - 20'h00001;
          end
        end
        default: begin
          state_q <= sir_pkg::SIR_ST_RUN;
        end
      endcase
    end
  end

  // output floats asleep; and while waking
  assign awake  = (state_q == sir_pkg::SIR_ST_RUN) || (state_q == sir_pkg::SIR_ST_ENTER);
  assign so_oe  = so_oe_q && awake;
  assign so     = so_q;
  assign status = '{state: state_q, mode: mode_q, overrun: overrun_q};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      endurance_cnt_q <= 32'h00000000;
    end else if (acc_start) begin
      endurance_cnt_q <= endurance_cnt_q + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // two clock domains here, so every property names its own clock
  sequence s_sleeping;
    state_q == sir_pkg::SIR_ST_SLEEP;
  endsequence

  chk_sleep_hiz_out : assert property (@(posedge clock) disable iff (!nrst) s_sleeping |-> !so_oe)
    else $error("output driven while asleep");
  chk_wake_hiz_out : assert property (@(posedge clock) disable iff (!nrst)
    state_q == sir_pkg::SIR_ST_WAKE |-> !so_oe)
    else $error("output driven while waking");
  chk_entry_timer_hold : assert property (@(posedge clock) disable iff (!nrst)
    state_q == sir_pkg::SIR_ST_ENTER && timer_q != 20'h00000 |=> state_q == sir_pkg::SIR_ST_ENTER)
    else $error("left entry before its time");
  chk_entry_ends_sleep : assert property (@(posedge clock) disable iff (!nrst)
    state_q == sir_pkg::SIR_ST_ENTER && timer_q == 20'h00000 |=> s_sleeping)
    else $error("entry did not reach sleep");
  chk_hib_fall_wake : assert property (@(posedge clock) disable iff (!nrst)
    s_sleeping and mode_q == sir_pkg::SIR_LP_HIB && cs_fall |=> state_q == sir_pkg::SIR_ST_WAKE ##1
    timer_q == $past(timer_q) - 20'h00001)
    else $error("hibernate did not wake on select fall");
  chk_short_pulse_stay : assert property (@(posedge clock) disable iff (!nrst)
    s_sleeping and mode_q == sir_pkg::SIR_LP_DEEP && cs_rise && low_cnt_q < WAKE_PULSE_CYC |=> s_sleeping)
    else $error("deep sleep left on short pulse");
  chk_wake_drop_op : assert property (@(posedge clock) disable iff (!nrst)
    state_q == sir_pkg::SIR_ST_WAKE |=> pend_q == sir_pkg::SIR_LP_NONE)
    else $error("opcode kept during wakeup");
  chk_row_count_step : assert property (@(posedge clock) disable iff (!nrst)
    acc_start |=> endurance_cnt_q == $past(endurance_cnt_q) + 32'h00000001)
    else $error("row access not counted once");
  chk_frame_end_hiz : assert property (@(posedge clock) disable iff (!nrst) cs_s_q && cs_d_q |-> !so_oe)
    else $error("output driven between frames");
  chk_sn_opcode_read : assert property (@(posedge sck) disable iff (!link_rst_n)
    op_end && byte_in == `SIR_OP_SN_READ |=> rd_sn_q)
    else $error("serial read opcode not taken");
  chk_sn_byte_wrap : assert property (@(negedge sck) disable iff (!link_rst_n)
    rd_sn_q && obit_q == 3'h7 && idx_q == 3'h7 |=> idx_q == 3'h0 && obit_q == 3'h0)
    else $error("serial number did not wrap");
  chk_sn_first_byte : assert property (@(negedge sck) disable iff (!link_rst_n)
    $rose(so_oe_q) |-> idx_q == 3'h0 && obit_q == 3'h1)
    else $error("serial read did not start at byte 0");

endmodule // sir_top
